/* inc/sea_mem_if.sv */
// write and read port between the loader and its descriptor memory
// assumes both ends run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface sea_mem_if;
    logic we;
    logic [5:0] waddr, raddr;
    logic [15:0] wdata, rdata;
    modport ctl (output we, waddr, wdata, raddr, input rdata);
    modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : sea_mem_if
`default_nettype wire

/* inc/sea_pkg.sv */
// constants, field positions and types shared by the auto-load design
// assumes a single 10 MHz clock and a word-organised serial config memory
package sea_pkg;
    localparam int CLK_HZ = 10_000_000;
    // least half period of the serial clock, rounded up to whole cycles
    localparam int SK_HALF_NS = 500;
    localparam int SK_HALF_CYC = (SK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SK_CNT_W = 4;
    localparam int EE_AW = 6;
    localparam int CMD_BITS = 9;
    localparam int DATA_BITS = 17;
    localparam logic EE_START = 1'b1;
    localparam logic [1:0] EE_RD_OP = 2'b10;
    // word indexes of the memory image (byte 2n is the low half of word n)
    localparam logic [5:0] W_SIG = 6'h00;
    localparam logic [5:0] W_STA0 = 6'h01;
    localparam logic [5:0] W_STA1 = 6'h02;
    localparam logic [5:0] W_STA2 = 6'h03;
    localparam logic [5:0] W_CFG = 6'h04;
    localparam logic [5:0] W_GP = 6'h05;
    localparam logic [5:0] W_USB_CONFIG_ATTRIBUTES = 6'h06;
    localparam logic [5:0] W_PHY1L = 6'h07;
    localparam logic [5:0] W_PHY1H = 6'h08;
    localparam logic [5:0] W_TWL = 6'h09;
    localparam logic [5:0] W_TWH = 6'h0A;
    localparam logic [5:0] W_PWR = 6'h0B;
    localparam logic [5:0] W_LANG = 6'h0C;
    localparam logic [5:0] W_VEND = 6'h0D;
    localparam logic [5:0] W_PROD = 6'h0E;
    localparam logic [5:0] W_DESC = 6'h0F;
    localparam int SER_BYTES = 10;
    localparam int MFG_BYTES = 40;
    localparam int PRD_BYTES = 46;
    localparam logic [5:0] W_LAST = 6'(W_DESC + (SER_BYTES + MFG_BYTES + PRD_BYTES) / 2 - 1);
    // bit positions in the media/mode byte and in the phy registers
    localparam int MB_DUP = 0;
    localparam int MB_PAUSE = 2;
    localparam int MB_ANE = 4;
    localparam int MB_SPD = 5;
    localparam int BM_DUP = 8;
    localparam int BM_ANE = 12;
    localparam int BM_SPD = 13;
    localparam int AN_PAUSE = 10;
    localparam logic [15:0] AUTONEG_ADVERT_REG_FIX = 16'h01E1;
    localparam int CMD_LOAD = 0;
    localparam int CMD_SIGOK = 1;
    // register indexes; byte address is four times the index
    localparam logic [9:0] R_IDR0 = 10'h120;
    localparam logic [9:0] R_CMD = 10'h12E;
    localparam logic [9:0] R_CFG0 = 10'h135;
    localparam logic [9:0] R_MSR = 10'h137;
    localparam logic [9:0] R_GP = 10'h13D;
    localparam logic [9:0] R_BASIC_MODE_CONTROL_REG = 10'h140;
    localparam logic [9:0] R_AUTONEG_ADVERT_REG = 10'h144;
    localparam logic [9:0] R_PHY1 = 10'h180;
    localparam logic [9:0] R_PHY2 = 10'h184;
    localparam logic [9:0] R_TW = 10'h186;
    localparam logic [9:0] R_UDP = 10'h190;
    localparam logic [9:0] R_USB_CONFIG_ATTRIBUTES = 10'h191;
    localparam logic [9:0] R_PWR = 10'h192;
    localparam logic [9:0] R_INTV = 10'h193;
    localparam logic [9:0] R_LANG = 10'h194;
    localparam logic [9:0] R_VEND = 10'h195;
    localparam logic [9:0] R_PROD = 10'h196;
    localparam logic [3:0] R_MEM_HI = 4'h8;
    typedef enum logic [1:0] {S_IDLE, S_CMD, S_DATA, S_GAP} sea_ser_type;
    typedef struct packed {
        logic [47:0] sta;
        logic [7:0] cfg0, media_status_reg, gp, usb_device_param, usb_config_attributes, phy2, pwr, intv;
        logic spd, autoneg_enable, dup, pause;
        logic [31:0] phy1, tw;
        logic [15:0] lang, vend, prod;
    } sea_tgt_type;
    localparam sea_tgt_type TGT_RST = '0;
endpackage : sea_pkg

/* rtl/sea_autoload.sv */
// serial configuration loader with classic wishbone register slave
// assumes i_rst_n is the external reset pin and the memory answers mode 16-bit
//
// Summary of operation
// RULE1 - load runs after reset release and on the software auto-load command
// RULE2 - memory is read as 16-bit words, 1K-bit in total
// RULE3 - word zero is checked against the signature before anything is copied
// RULE4 - bytes 02h-07h go in order into the six station address bytes
// RULE5 - byte 08h goes into configuration register zero
// RULE6 - media byte bits 7:6 go into media status bits 7:6
// RULE7 - media byte bits 5,4,0 go into control bits 13,12,8
// RULE8 - media byte bit 2 goes inverted into advertise pause bit 10
// RULE9 - byte 0Ah goes into the general purpose pin control register
// RULE10 - byte 0Dh goes into the phy parameter two register
// RULE11 - bytes 0Eh-11h go into the four phy parameter one bytes
// RULE12 - bytes 12h-15h go into the four line tuning bytes
// RULE13 - stored attribute bit 5 means remote wakeup, bit 6 self powered
// RULE14 - stored attribute bit 7 is one and bits 4:0 are zero
// RULE15 - maximum bus power comes from byte 16h
// RULE16 - endpoint 3 polling interval comes from byte 17h
// RULE17 - language id comes from bytes 18h-19h
// RULE18 - vendor and product ids come from bytes 1Ah-1Dh
// RULE19 - ten serial number bytes come from bytes 1Eh-27h
// RULE20 - manufacturer string comes from 28h-4Fh, at most 40 bytes
// RULE21 - product string comes from 50h-7Dh, at most 46 bytes
// RULE22 - with autoneg on, speed and duplex report negotiated values, not forced
// RULE23 - bad signature leaves defaults in all targets and ends the load; the descriptor word store keeps its earlier contents
// RULE24 - each word read: select, start, opcode, address, then sixteen bits
`timescale 1ns/10ps
`default_nettype none
module sea_autoload import sea_pkg::*; #(
    parameter int SK_HALF = SK_HALF_CYC,
    parameter logic [15:0] SIG = 16'hC35A // arbitrary signature value
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [11:2] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    output logic o_ee_cs,
    output logic o_ee_sk,
    output logic o_ee_di,
    input wire logic i_ee_do,
    input wire logic i_neg_speed_100,
    input wire logic i_neg_full_duplex,
    output logic o_load_busy,
    output logic [47:0] o_station_addr,
    output logic o_autoneg_enable,
    output logic o_force_speed_100,
    output logic o_force_full_duplex,
    output logic o_pause_adv,
    output logic [7:0] o_max_bus_power,
    output logic [7:0] o_ep3_interval,
    output logic [15:0] o_lang_id,
    output logic [15:0] o_vendor_id,
    output logic [15:0] o_product_id
);
    localparam logic [SK_CNT_W-1:0] DIV_LD = SK_CNT_W'(SK_HALF - 1);

    typedef struct packed {
        sea_ser_type ser;
        logic [SK_CNT_W-1:0] div;
        logic [4:0] bit_n;
        logic [5:0] word;
        logic [15:0] shift;
        logic cs, sk, di, sy1, sy2;
        logic busy, start, sig_ok;
        sea_tgt_type tgt;
        logic frc_spd, frc_dup;
        logic pend, ack;
        logic [31:0] dat;
        logic [9:0] radr;
    } sea_st_type;

    sea_st_type st, next_st;
    logic tick, dlv;
    logic [15:0] dword;
    logic [CMD_BITS-1:0] cmd_word;

    generate
        // the data bit needs two sync stages plus one edge before the sampling fall
        if (SK_HALF < 3 || SK_HALF > 2 ** SK_CNT_W) begin : g_bad_div
            $error("serial clock half period does not fit the divider");
        end
    endgenerate

    sea_mem_if u_if ();
    sea_desc_mem #(.DEPTH(2 ** EE_AW)) u_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .bus(u_if)
    );

    function automatic logic [7:0] byte_of(input logic [47:0] v, input int i);
        byte_of = v[8*i +: 8];
    endfunction : byte_of

    function automatic logic in_rng(input logic [9:0] a, input logic [9:0] b,
                                    input int n);
        in_rng = (a >= b) && (int'(a) < int'(b) + n);
    endfunction : in_rng

    // copy one fetched word into its targets
    function automatic sea_tgt_type put_word(input sea_tgt_type t,
                                             input logic [5:0] w,
                                             input logic [15:0] d);
        put_word = t;
        case (w)
            // RULE4 station address order
            W_STA0: put_word.sta[15:0] = d;
            W_STA1: put_word.sta[31:16] = d;
            W_STA2: put_word.sta[47:32] = d;
            W_CFG: begin
                // RULE5 config zero
                put_word.cfg0 = d[7:0];
                // RULE6 media status bits
                put_word.media_status_reg[7:6] = d[15:14];
                // RULE7 speed, autoneg, duplex
                put_word.spd = d[8+MB_SPD];
                put_word.autoneg_enable = d[8+MB_ANE];
                put_word.dup = d[8+MB_DUP];
                // RULE8 stored zero advertises pause
                put_word.pause = !d[8+MB_PAUSE];
            end
            W_GP: begin
                // RULE9 gp pin control
                put_word.gp = d[7:0];
                put_word.usb_device_param = d[15:8];
            end
            W_USB_CONFIG_ATTRIBUTES: begin
                put_word.usb_config_attributes = d[7:0];
                // RULE10 phy parameter two
                put_word.phy2 = d[15:8];
            end
            // RULE11 phy parameter one
            W_PHY1L: put_word.phy1[15:0] = d;
            W_PHY1H: put_word.phy1[31:16] = d;
            // RULE12 line tuning bytes
            W_TWL: put_word.tw[15:0] = d;
            W_TWH: put_word.tw[31:16] = d;
            W_PWR: begin
                // RULE15 max bus power
                put_word.pwr = d[7:0];
                // RULE16 polling interval
                put_word.intv = d[15:8];
            end
            // RULE17 language id
            W_LANG: put_word.lang = d;
            // RULE18 vendor and product
            W_VEND: put_word.vend = d;
            W_PROD: put_word.prod = d;
            default: ;
        endcase
    endfunction : put_word

    function automatic logic [31:0] rd_reg(input sea_tgt_type t,
                                           input logic [9:0] a,
                                           input logic nspd, input logic ndup,
                                           input logic busy, input logic sok);
        rd_reg = '0;
        if (in_rng(a, R_IDR0, 6)) begin
            rd_reg[7:0] = byte_of(t.sta, int'(a - R_IDR0));
        end
        if (in_rng(a, R_PHY1, 4)) begin
            rd_reg[7:0] = byte_of({16'h0000, t.phy1}, int'(a - R_PHY1));
        end
        if (in_rng(a, R_TW, 4)) begin
            rd_reg[7:0] = byte_of({16'h0000, t.tw}, int'(a - R_TW));
        end
        case (a)
            R_CMD: begin
                rd_reg[CMD_LOAD] = busy;
                rd_reg[CMD_SIGOK] = sok;
            end
            R_CFG0: rd_reg[7:0] = t.cfg0;
            R_MSR: rd_reg[7:0] = t.media_status_reg;
            R_GP: rd_reg[7:0] = t.gp;
            R_BASIC_MODE_CONTROL_REG: begin
                // RULE22 negotiated result shows
                rd_reg[BM_SPD] = t.autoneg_enable ? nspd : t.spd;
                rd_reg[BM_ANE] = t.autoneg_enable;
                rd_reg[BM_DUP] = t.autoneg_enable ? ndup : t.dup;
            end
            R_AUTONEG_ADVERT_REG: begin
                rd_reg[15:0] = AUTONEG_ADVERT_REG_FIX;
                rd_reg[AN_PAUSE] = t.pause;
            end
            R_PHY2: rd_reg[7:0] = t.phy2;
            R_UDP: rd_reg[7:0] = t.usb_device_param;
            R_USB_CONFIG_ATTRIBUTES: rd_reg[7:0] = t.usb_config_attributes;
            R_PWR: rd_reg[7:0] = t.pwr;
            R_INTV: rd_reg[7:0] = t.intv;
            R_LANG: rd_reg[15:0] = t.lang;
            R_VEND: rd_reg[15:0] = t.vend;
            R_PROD: rd_reg[15:0] = t.prod;
            default: ;
        endcase
    endfunction : rd_reg

    always_comb begin
        next_st = st;
        next_st.sy1 = i_ee_do;
        next_st.sy2 = st.sy1;
        tick = (st.div == '0);
        next_st.div = tick ? DIV_LD : st.div - 1'b1;
        dword = {st.shift[14:0], st.sy2};
        cmd_word = {EE_START, EE_RD_OP, st.word};
        dlv = 1'b0;
        u_if.we = 1'b0;
        u_if.waddr = st.word;
        u_if.wdata = dword;
        case (st.ser)
            S_IDLE: begin
                // RULE1 load on reset or command
                if (st.start && tick) begin
                    next_st.start = 1'b0;
                    next_st.busy = 1'b1;
                    next_st.word = W_SIG;
                    next_st.bit_n = '0;
                    next_st.cs = 1'b1;
                    next_st.di = EE_START;
                    next_st.ser = S_CMD;
                end
            end
            S_CMD: begin
                // RULE24 start, opcode, address out
                if (tick) begin
                    next_st.sk = !st.sk;
                    if (st.sk) begin
                        if (int'(st.bit_n) == CMD_BITS - 1) begin
                            next_st.di = 1'b0;
                            next_st.bit_n = '0;
                            next_st.ser = S_DATA;
                        end else begin
                            next_st.bit_n = st.bit_n + 1'b1;
                            next_st.di = cmd_word[CMD_BITS - 2 - int'(st.bit_n)];
                        end
                    end
                end
            end
            S_DATA: begin
                // RULE2 sixteen bits per word
                if (tick) begin
                    next_st.sk = !st.sk;
                    if (st.sk) begin
                        next_st.shift = dword;
                        next_st.bit_n = st.bit_n + 1'b1;
                        if (int'(st.bit_n) == DATA_BITS - 1) begin
                            dlv = 1'b1;
                            next_st.cs = 1'b0;
                            next_st.ser = S_GAP;
                        end
                    end
                end
            end
            S_GAP: begin
                if (tick) begin
                    // RULE23 a bad signature ends the load
                    if (st.word == W_LAST || !st.sig_ok) begin
                        next_st.busy = 1'b0;
                        next_st.ser = S_IDLE;
                    end else begin
                        next_st.word = st.word + 1'b1;
                        next_st.bit_n = '0;
                        next_st.cs = 1'b1;
                        next_st.di = EE_START;
                        next_st.ser = S_CMD;
                    end
                end
            end
            default: next_st.ser = S_IDLE;
        endcase
        if (dlv) begin
            if (st.word == W_SIG) begin
                // RULE3 signature gate
                next_st.sig_ok = (dword == SIG);
                // RULE23 defaults on mismatch
                if (dword != SIG) begin
                    next_st.tgt = TGT_RST;
                end
            end else if (st.sig_ok) begin
                next_st.tgt = put_word(st.tgt, st.word, dword);
                // RULE19 serial and strings into store
                // RULE20 manufacturer string capped
                // RULE21 product string capped
                u_if.we = (st.word >= W_DESC) && (st.word <= W_LAST);
            end
        end
        next_st.ack = 1'b0;
        if (st.pend) begin
            next_st.pend = 1'b0;
            next_st.ack = 1'b1;
            if (st.radr[9:6] == R_MEM_HI) begin
                next_st.dat = {16'h0000, u_if.rdata};
            end else begin
                next_st.dat = rd_reg(st.tgt, st.radr, i_neg_speed_100,
                                     i_neg_full_duplex, st.busy || st.start, st.sig_ok);
            end
            if (i_wb_we && i_wb_sel[0]) begin
                if (in_rng(st.radr, R_IDR0, 6)) begin
                    next_st.tgt.sta[8*int'(st.radr - R_IDR0) +: 8] = i_wb_dat[7:0];
                end
                case (st.radr)
                    R_CMD: begin
                        // RULE1 software auto-load
                        if (i_wb_dat[CMD_LOAD] && !st.busy) begin
                            next_st.start = 1'b1;
                        end
                    end
                    R_CFG0: next_st.tgt.cfg0 = i_wb_dat[7:0];
                    R_MSR: next_st.tgt.media_status_reg = i_wb_dat[7:0];
                    R_GP: next_st.tgt.gp = i_wb_dat[7:0];
                    default: ;
                endcase
            end
            if (i_wb_we && i_wb_sel[1] && st.radr == R_BASIC_MODE_CONTROL_REG) begin
                next_st.tgt.spd = i_wb_dat[BM_SPD];
                next_st.tgt.autoneg_enable = i_wb_dat[BM_ANE];
                next_st.tgt.dup = i_wb_dat[BM_DUP];
            end
        end else if (i_wb_cyc && i_wb_stb && !st.ack) begin
            next_st.pend = 1'b1;
            next_st.radr = i_wb_adr;
        end
        // RULE22 no forcing under autoneg
        next_st.frc_spd = !next_st.tgt.autoneg_enable && next_st.tgt.spd;
        next_st.frc_dup = !next_st.tgt.autoneg_enable && next_st.tgt.dup;
    end

    assign u_if.raddr = i_wb_adr[7:2];

    // start is set by reset so the first load follows reset release
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '{ser: S_IDLE, start: 1'b1, tgt: TGT_RST, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign o_wb_ack = st.ack;
    assign o_wb_dat = st.dat;
    assign o_ee_cs = st.cs;
    assign o_ee_sk = st.sk;
    assign o_ee_di = st.di;
    assign o_load_busy = st.busy;
    assign o_station_addr = st.tgt.sta;
    assign o_autoneg_enable = st.tgt.autoneg_enable;
    assign o_force_speed_100 = st.frc_spd;
    assign o_force_full_duplex = st.frc_dup;
    assign o_pause_adv = st.tgt.pause;
    assign o_max_bus_power = st.tgt.pwr;
    assign o_ep3_interval = st.tgt.intv;
    assign o_lang_id = st.tgt.lang;
    assign o_vendor_id = st.tgt.vend;
    assign o_product_id = st.tgt.prod;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_cmd_wr;
        st.pend && i_wb_we && i_wb_sel[0] && st.radr == R_CMD
            && i_wb_dat[CMD_LOAD] && !st.busy && !st.start;
    endsequence
    sequence s_word_done;
        dlv && st.sig_ok;
    endsequence

    a_cmd_starts: assert property (s_cmd_wr |=> st.start ##[1:16] st.busy) // RULE1
        else $error("auto-load command did not start a load");
    a_word_range: assert property (st.busy |-> st.word <= W_LAST) // RULE2
        else $error("word address beyond the last stored word");
    a_sig_gate: assert property (u_if.we |-> st.sig_ok && st.word >= W_DESC) // RULE3
        else $error("store written without a good signature");
    a_sta_copy: assert property (s_word_done ##0 (st.word == W_STA0) // RULE4
        |=> st.tgt.sta[7:0] == $past(dword[7:0]))
        else $error("first station byte not copied");
    a_pause_inv: assert property (s_word_done ##0 (st.word == W_CFG) // RULE8
        |=> st.tgt.pause == !$past(dword[8+MB_PAUSE]))
        else $error("pause advertise not inverted");
    a_bad_defaults: assert property (dlv && st.word == W_SIG && dword != SIG // RULE23
        |=> st.tgt == TGT_RST && !st.sig_ok ##[1:16] !st.busy)
        else $error("bad signature did not restore defaults and finish");
    a_ane_noforce: assert property (st.tgt.autoneg_enable // RULE22
        |-> !o_force_speed_100 && !o_force_full_duplex)
        else $error("link forced while autoneg enabled");
    a_sk_frame: assert property (st.sk |-> st.cs) // RULE24
        else $error("serial clock high outside a frame");
    a_sk_paced: assert property ($changed(st.sk) |-> $past(tick)) // RULE24
        else $error("serial clock moved off the divider tick");
    a_wb_answer: assert property (i_wb_cyc && i_wb_stb && !st.pend && !st.ack
        |=> st.pend ##1 o_wb_ack ##1 !o_wb_ack)
        else $error("bus answer not two cycles after request");
endmodule : sea_autoload
`default_nettype wire

/* rtl/sea_desc_mem.sv */
// descriptor word store: one write port, one registered read port
// assumes the loader is the only writer
`timescale 1ns/10ps
`default_nettype none
module sea_desc_mem import sea_pkg::*; #(
    parameter int DEPTH = 64
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    sea_mem_if.mem bus
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] ram;
        logic [15:0] rd;
    } sea_mst_type;
    sea_mst_type st, next_st;
    generate
        if (DEPTH != 2 ** EE_AW) begin : g_bad_depth
            $error("descriptor depth must match the word address range");
        end
    endgenerate
    always_comb begin
        next_st = st;
        next_st.rd = st.ram[bus.raddr];
        if (bus.we) begin
            next_st.ram[bus.waddr] = bus.wdata;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign bus.rdata = st.rd;
endmodule : sea_desc_mem
`default_nettype wire

/* sim/sea_autoload_tb.sv */
// self-checking bench for the auto-load block with a memory model behind it
// assumes the default serial clock divider; two full loads and a one-word load fit well under the watchdog
`timescale 1ns/10ps
`default_nettype none
module sea_autoload_tb import sea_pkg::*;;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
    localparam logic [15:0] SIG_T = 16'hC35A; // arbitrary, matches the design default
    logic i_clk, i_rst_n, cyc, stb, we, ack, cs, sk, di, dout, ns, nd, busy, autoneg_enable, fs, fd, pa;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd;
    logic [47:0] sta;
    logic [7:0] pwr, intv;
    logic [15:0] lang, vend, prod;
    int error_cnt, n_checks, reads, bad, r0;
    sea_autoload #(.SIG(SIG_T)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .o_ee_cs(cs), .o_ee_sk(sk), .o_ee_di(di),
        .i_ee_do(dout), .i_neg_speed_100(ns), .i_neg_full_duplex(nd), .o_load_busy(busy),
        .o_station_addr(sta), .o_autoneg_enable(autoneg_enable), .o_force_speed_100(fs),
        .o_force_full_duplex(fd), .o_pause_adv(pa), .o_max_bus_power(pwr),
        .o_ep3_interval(intv), .o_lang_id(lang), .o_vendor_id(vend), .o_product_id(prod));
    sea_ee_model ee (.i_cs(cs), .i_sk(sk), .i_di(di), .o_do(dout), .o_reads(reads), .o_bad(bad));
    function automatic logic [7:0] bt(input int b);
        return 8'(b * 29 + 7);
    endfunction : bt
    task automatic fill(input logic [15:0] sig, input logic [7:0] media);
        for (int w = 0; w < 64; w++) ee.mem[w] = {bt(2 * w + 1), bt(2 * w)};
        ee.mem[0] = sig;
        ee.mem[4] = {media, bt(8)};
        ee.mem[6] = {bt(13), 8'hA0};
    endtask : fill
    task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
        n = 0;
        do begin @(posedge i_clk); n++; end while (ack !== 1'b1 && n < 50);
        rd = rdat;
        `CHK(ack, 1'b1)
        {cyc, stb, we} <= 3'b000;
        @(posedge i_clk);
    endtask : wb
    task automatic rchk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(rd & m, e)
    endtask : rchk
    task automatic wait_load;
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 100) begin @(posedge i_clk); n++; end
        n = 0;
        while (busy !== 1'b0 && n < 40000) begin @(posedge i_clk); n++; end
        `CHK(busy, 1'b0)
    endtask : wait_load
    task automatic t_good;
        wait_load;
        `CHK(sta, {bt(7), bt(6), bt(5), bt(4), bt(3), bt(2)})
        `CHK({fs, autoneg_enable, fd, pa}, 4'b1010)
        `CHK(pwr, bt(22))
        `CHK(intv, bt(23))
        `CHK(lang, {bt(25), bt(24)})
        `CHK({vend, prod}, {bt(27), bt(26), bt(29), bt(28)})
        `CHK(reads, 63)
        `CHK(bad, 0)
        rchk(R_CFG0, 32'hFFFF_FFFF, {24'h0, bt(8)});
        rchk(R_MSR, 32'hC0, 32'hC0);
        rchk(R_GP, 32'hFFFF_FFFF, {24'h0, bt(10)});
        rchk(R_PHY2, 32'hFFFF_FFFF, {24'h0, bt(13)});
        rchk(R_USB_CONFIG_ATTRIBUTES, 32'hFFFF_FFFF, 32'hA0);
        rchk(R_PHY1, 32'hFF, {24'h0, bt(14)});
        rchk(R_TW, 32'hFF, {24'h0, bt(18)});
        rchk(R_AUTONEG_ADVERT_REG, 32'hFFFF, 32'h01E1);
        rchk(R_CMD, 32'h2, 32'h2);
        rchk(10'h20F, 32'hFFFF, {16'h0, bt(31), bt(30)});
        rchk(10'h214, 32'hFFFF, {16'h0, bt(41), bt(40)});
        rchk(10'h23E, 32'hFFFF, {16'h0, bt(125), bt(124)});
        rchk(10'h010, 32'hFFFF_FFFF, 32'h0);
    endtask : t_good
    task automatic t_autoneg;
        fill(SIG_T, 8'h10);
        ns <= 1'b1;
        nd <= 1'b0;
        r0 = reads;
        wb(1'b1, R_CMD, 32'h1);
        wait_load;
        `CHK({autoneg_enable, fs, fd, pa}, 4'b1001)
        `CHK(reads - r0, 63)
        rchk(R_BASIC_MODE_CONTROL_REG, 32'h3100, 32'h3000);
        rchk(R_AUTONEG_ADVERT_REG, 32'hFFFF, 32'h05E1);
    endtask : t_autoneg
    task automatic t_badsig;
        fill(~SIG_T, 8'hE5);
        r0 = reads;
        wb(1'b1, R_CMD, 32'h1);
        wait_load;
        `CHK({sta, autoneg_enable, pa, pwr, vend}, '0)
        `CHK(reads - r0, 1)
        rchk(R_CMD, 32'h2, 32'h0);
        rchk(R_CFG0, 32'hFF, 32'h0);
    endtask : t_badsig
    task automatic results;
        $display("errors=%0d checks=%0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, cyc, stb, we, ns, nd, adr, sel, wdat} = '0;
        error_cnt = 0;
        n_checks = 0;
        fill(SIG_T, 8'hE5);
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_good;
        t_autoneg;
        t_badsig;
        results;
    end
    initial begin
        repeat (80000) @(posedge i_clk);
        error_cnt++;
        results;
    end
endmodule : sea_autoload_tb
`default_nettype wire

/* sim/sea_ee_model.sv */
// word-organised serial config memory model, 64 words of 16 bits
// assumes the loader drives select, serial clock and data in; image set by the bench
`timescale 1ns/10ps
`default_nettype none
module sea_ee_model (
    input wire logic i_cs,
    input wire logic i_sk,
    input wire logic i_di,
    output logic o_do,
    output int o_reads,
    output int o_bad
);
    logic [15:0] mem [64];
    logic [8:0] cmd;
    logic [15:0] dq;
    logic [5:0] prev;
    int n;
    initial begin
        o_do = 1'b0;
        o_reads = 0;
        o_bad = 0;
        n = 0;
        prev = 6'h3F;
    end
    // start, read opcode, six-bit word address, then sixteen bits
    always @(posedge i_sk) begin
        if (i_cs) begin
            n = n + 1;
            if (n <= 9) cmd = {cmd[7:0], i_di};
            if (n == 9) begin
                o_reads++;
                dq = mem[cmd[5:0]];
                if (cmd[8:6] !== 3'b110 || (cmd[5:0] !== 6'h00 && cmd[5:0] !== prev + 6'h01))
                    o_bad++;
                prev = cmd[5:0];
            end
            if (n >= 10 && n <= 26) o_do = (n == 10) ? 1'b0 : dq[26 - n];
        end
    end
    // released line floats: show the inverse so a stale value is never taken for data
    always @(negedge i_cs) begin
        n = 0;
        o_do = ~o_do;
    end
endmodule : sea_ee_model
`default_nettype wire
